// ---- verilog/usm_master.sv ----
/*
  Holds the master SPI transfer controller of the serial unit: double-buffered transmit,
  buffered receive, four clock modes, selectable bit order, internal clock only.
  Assumes configuration arrives on plain ports and data writes/reads arrive as one-cycle strobes.
*/
//
// Operation
// RULE_01: Both mode select bits one enables SPI.
// RULE_02: Parity, recovery, async control disabled here.
// RULE_03: Serial clock only generated internally, master.
// RULE_04: Software sets clock pin as output.
// RULE_05: Clock rate is fosc over 2(divisor+1).
// RULE_06: Divisor is twelve bits, high and low.
// RULE_07: Fastest serial clock is half system clock.
// RULE_08: Polarity and phase choose modes zero-three.
// RULE_09: Shift and sample on opposite edges.
// RULE_10: Software keeps polarity, phase steady mid-transfer.
// RULE_11: Frame is exactly eight data bits.
// RULE_12: One order bit serves both directions.
// RULE_13: Next frame follows or data idles high.
// RULE_14: Transmit and receive paths double buffered.
// RULE_15: Two writes give sixteen bits, one completion.
// RULE_16: Software enables transmitter with divisor zero.
// RULE_17: Divisor resets to zero.
// RULE_18: Receiver needs transmitter for its clock.
// RULE_19: Software idles link before reconfiguring.
// RULE_20: Pins, events, locations match normal mode.
// RULE_21: Data write starts transfer both ways.
// RULE_22: On overflow newest received byte dropped.
// RULE_23: Frame, overrun, parity flags read zero.
// RULE_24: Eight clock cycles per frame, byte stored.
module usm_master
  import usm_pkg::*;
#(
  parameter int DATA_WIDTH = `USM_FRAME_BITS,
  parameter int FIFO_DEPTH = `USM_FIFO_DEPTH,
  parameter int DIV_WIDTH  = `USM_DIV_WIDTH
) (
  // Clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  SYS_RST,
  // Configuration
  input  wire logic                  MODE_SELECT_HIGH,
  input  wire logic                  MODE_SELECT_LOW,
  input  wire logic                  CLOCK_POLARITY_BIT,
  input  wire logic                  CLOCK_PHASE_BIT,
  input  wire logic                  DATA_ORDER_BIT,
  input  wire logic                  TRANSMITTER_ENABLE,
  input  wire logic                  RECEIVER_ENABLE,
  input  wire logic                  SERIAL_CLOCK_PIN_DIRECTION,
  // Divisor write
  input  wire logic [DIV_WIDTH-9:0]  BAUD_DIVISOR_HIGH,
  input  wire logic                  BAUD_DIVISOR_HIGH_WRITE,
  input  wire logic [7:0]            BAUD_DIVISOR_LOW,
  input  wire logic                  BAUD_DIVISOR_LOW_WRITE,
  // Data buffer
  input  wire logic [DATA_WIDTH-1:0] DATA_WRITE,
  input  wire logic                  DATA_WRITE_STROBE,
  input  wire logic                  DATA_READ_STROBE,
  input  wire logic                  TRANSMIT_COMPLETE_CLEAR,
  // Status
  output logic      [DATA_WIDTH-1:0] DATA_READ,
  output logic                       RECEIVE_COMPLETE_FLAG,
  output logic                       TRANSMIT_COMPLETE_FLAG,
  output logic                       DATA_REGISTER_EMPTY_FLAG,
  output logic                       FRAME_ERROR_FLAG,
  output logic                       DATA_OVERRUN_FLAG,
  output logic                       PARITY_ERROR_FLAG,
  output logic      [DIV_WIDTH-1:0]  BAUD_DIVISOR,
  // Serial pins
  output logic                       SERIAL_CLOCK_PIN,
  output logic                       SERIAL_CLOCK_PIN_OE_N,
  output logic                       SERIAL_DATA_OUT,
  input  wire logic                  SERIAL_DATA_IN
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    usm_state_type                     fsm;
    logic [DIV_WIDTH-1:0]              baud_divisor;
    logic [DATA_WIDTH-1:0]             tx_shift;
    logic [DATA_WIDTH-1:0]             rx_shift;
    logic [`USM_BIT_CNT_WIDTH-1:0]     bit_count;
    logic                              sck;
    logic                              sdo;
    logic                              tx_full;
    logic [DATA_WIDTH-1:0]             tx_hold;
    logic                              txc;
    logic [DATA_WIDTH-1:0]             rd_data;
    logic                              rxc;
    logic                              udre;
  } usm_master_state_type;

  usm_master_state_type state;
  usm_master_state_type next_state;

  logic                  spi_on;
  logic                  tick;
  logic                  rx_in_ready;
  logic                  rx_push;
  logic [DATA_WIDTH-1:0] rx_out_data;
  logic                  rx_out_valid;
  logic                  rx_pop;
  logic [DATA_WIDTH-1:0] rx_byte;
  logic                  sample_bit;
  logic [DATA_WIDTH-1:0] sampled;
  logic                  load_ok;

  assign spi_on = (MODE_SELECT_HIGH && MODE_SELECT_LOW) && TRANSMITTER_ENABLE; // [RULE_01] [RULE_18]

  // ****************************************
  // Baud generator
  // ****************************************
  usm_baud #(
    .DIV_WIDTH (DIV_WIDTH)
  ) u_baud (
    .clock   (CLOCK),
    .sys_rst (SYS_RST),
    .run     (spi_on && state.fsm != USM_IDLE), // [RULE_05] [RULE_07]
    .divisor (state.baud_divisor),
    .tick    (tick)
  );

  // ****************************************
  // Receive buffer
  // ****************************************
  assign sample_bit = SERIAL_DATA_IN;
  assign sampled    = DATA_ORDER_BIT ? {state.rx_shift[DATA_WIDTH-2:0], sample_bit}
                                     : {sample_bit, state.rx_shift[DATA_WIDTH-1:1]}; // [RULE_12]
  assign rx_byte    = CLOCK_PHASE_BIT ? sampled : state.rx_shift; // [RULE_24]
  assign rx_push    = RECEIVER_ENABLE && tick && state.fsm == USM_TRAIL
                      && state.bit_count == `USM_BIT_CNT_WIDTH'(DATA_WIDTH - 1); // [RULE_24]
  assign rx_pop     = rx_out_valid && (!state.rxc || DATA_READ_STROBE);

  usm_fifo #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (CLOCK),
    .sys_rst   (SYS_RST),
    .in_data   (rx_byte),
    .in_valid  (rx_push), // [RULE_22]
    .in_ready  (rx_in_ready),
    .out_data  (rx_out_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .flush     (!RECEIVER_ENABLE)
  ); // [RULE_14]

  assign load_ok = state.fsm == USM_IDLE || (state.fsm == USM_DONE);

  // ****************************************
  // Transfer control
  // ****************************************
  always_comb begin
    next_state = state;
    if (BAUD_DIVISOR_HIGH_WRITE) begin
      next_state.baud_divisor[DIV_WIDTH-1:8] = BAUD_DIVISOR_HIGH; // [RULE_06]
    end
    if (BAUD_DIVISOR_LOW_WRITE) begin
      next_state.baud_divisor[7:0] = BAUD_DIVISOR_LOW; // [RULE_06]
    end
    if (TRANSMIT_COMPLETE_CLEAR) begin
      next_state.txc = 1'b0;
    end
    if (DATA_WRITE_STROBE && !state.tx_full && spi_on) begin
      next_state.tx_full = 1'b1; // [RULE_21] [RULE_14]
      next_state.tx_hold = DATA_WRITE;
    end
    if (DATA_READ_STROBE) begin
      next_state.rxc = 1'b0;
    end
    if (rx_pop) begin
      next_state.rxc     = 1'b1;
      next_state.rd_data = rx_out_data;
    end
    if (!RECEIVER_ENABLE) begin
      next_state.rxc = 1'b0;
    end
    if (!spi_on) begin
      next_state.fsm     = USM_IDLE;
      next_state.tx_full = 1'b0;
      next_state.sck     = CLOCK_POLARITY_BIT;
      next_state.sdo     = 1'b1;
    end else begin
      case (state.fsm)
        USM_IDLE, USM_DONE: begin
          next_state.sck = CLOCK_POLARITY_BIT;
          if (state.tx_full) begin
            next_state.fsm       = USM_LEAD; // [RULE_13]
            next_state.tx_full   = DATA_WRITE_STROBE && state.tx_full ? 1'b0 : 1'b0;
            next_state.tx_shift  = state.tx_hold;
            next_state.bit_count = '0;
            if (!CLOCK_PHASE_BIT) begin
              next_state.sdo = DATA_ORDER_BIT ? state.tx_hold[DATA_WIDTH-1] : state.tx_hold[0]; // [RULE_08]
            end
          end else begin
            next_state.fsm = USM_IDLE;
            next_state.sdo = 1'b1; // [RULE_13]
          end
        end
        USM_LEAD: begin
          if (tick) begin
            next_state.sck = !CLOCK_POLARITY_BIT; // [RULE_08]
            next_state.fsm = USM_TRAIL;
            if (CLOCK_PHASE_BIT) begin
              next_state.sdo = DATA_ORDER_BIT ? state.tx_shift[DATA_WIDTH-1] : state.tx_shift[0]; // [RULE_09]
            end else begin
              next_state.rx_shift = sampled; // [RULE_09]
            end
          end
        end
        USM_TRAIL: begin
          if (tick) begin
            next_state.sck = CLOCK_POLARITY_BIT;
            if (CLOCK_PHASE_BIT) begin
              next_state.rx_shift = sampled; // [RULE_09]
            end
            next_state.tx_shift = DATA_ORDER_BIT ? {state.tx_shift[DATA_WIDTH-2:0], 1'b1}
                                                 : {1'b1, state.tx_shift[DATA_WIDTH-1:1]}; // [RULE_11]
            if (state.bit_count == `USM_BIT_CNT_WIDTH'(DATA_WIDTH - 1)) begin
              next_state.fsm = USM_DONE; // [RULE_24]
              if (!state.tx_full) begin
                next_state.txc = 1'b1; // [RULE_15]
              end
            end else begin
              next_state.bit_count = state.bit_count + 1'b1;
              next_state.fsm       = USM_LEAD;
              if (!CLOCK_PHASE_BIT) begin
                next_state.sdo = DATA_ORDER_BIT ? state.tx_shift[DATA_WIDTH-2] : state.tx_shift[1]; // [RULE_09]
              end
            end
          end
        end
        default: begin
          next_state.fsm = USM_IDLE;
        end
      endcase
      if (state.fsm != USM_IDLE && state.fsm != USM_DONE && state.tx_full == 1'b0
          && DATA_WRITE_STROBE) begin
        next_state.tx_full = 1'b1; // [RULE_14]
        next_state.tx_hold = DATA_WRITE;
      end
    end
    next_state.udre = !next_state.tx_full;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state              <= '0;
      state.fsm          <= USM_IDLE;
      state.baud_divisor <= `USM_DIV_RESET; // [RULE_17]
      state.sdo          <= 1'b1;
      state.udre         <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      DATA_READ                <= '0;
      RECEIVE_COMPLETE_FLAG    <= 1'b0;
      TRANSMIT_COMPLETE_FLAG   <= 1'b0;
      DATA_REGISTER_EMPTY_FLAG <= 1'b1;
      FRAME_ERROR_FLAG         <= 1'b0;
      DATA_OVERRUN_FLAG        <= 1'b0;
      PARITY_ERROR_FLAG        <= 1'b0;
      BAUD_DIVISOR             <= `USM_DIV_RESET;
      SERIAL_CLOCK_PIN         <= 1'b0;
      SERIAL_CLOCK_PIN_OE_N    <= 1'b1;
      SERIAL_DATA_OUT          <= 1'b1;
    end else begin
      DATA_READ                <= next_state.rd_data;
      RECEIVE_COMPLETE_FLAG    <= next_state.rxc;
      TRANSMIT_COMPLETE_FLAG   <= next_state.txc;
      DATA_REGISTER_EMPTY_FLAG <= next_state.udre;
      FRAME_ERROR_FLAG         <= 1'b0; // [RULE_23] [RULE_02]
      DATA_OVERRUN_FLAG        <= 1'b0; // [RULE_23]
      PARITY_ERROR_FLAG        <= 1'b0; // [RULE_23]
      BAUD_DIVISOR             <= next_state.baud_divisor;
      SERIAL_CLOCK_PIN         <= next_state.sck; // [RULE_03]
      SERIAL_CLOCK_PIN_OE_N    <= !SERIAL_CLOCK_PIN_DIRECTION; // [RULE_04] [RULE_20]
      SERIAL_DATA_OUT          <= next_state.sdo;
    end
  end

endmodule : usm_master

// ---- verilog/usm_defines.svh ----
/*
  Holds the offsets-free constants of the master SPI block: field widths, reset values, timing.
  Assumes inclusion by bare name from the package; the modules use its macros without including it.
*/
`ifndef USM_DEFINES_SVH
`define USM_DEFINES_SVH

// ****************************************
// Widths and reset values
// ****************************************
`define USM_DIV_WIDTH      12
`define USM_DIV_RESET      12'h000
`define USM_FRAME_BITS     8
`define USM_BIT_CNT_WIDTH  4
`define USM_MODE_SPI       2'h3
`define USM_FIFO_DEPTH     32
`define USM_CLK_PERIOD_NS  100

`endif

// ---- verilog/usm_pkg.sv ----
/*
  Types of the master SPI block: transfer states and carried groups.
  Assumes usm_defines.svh on the include path.
*/
`include "usm_defines.svh"

package usm_pkg;

  // ****************************************
  // State encoding
  // ****************************************
  typedef enum logic [1:0] {
    USM_IDLE  = 2'b00,
    USM_LEAD  = 2'b01,
    USM_TRAIL = 2'b11,
    USM_DONE  = 2'b10
  } usm_state_type;

  // ****************************************
  // Configuration group
  // ****************************************
  typedef struct packed {
    logic                        mode_select_high;
    logic                        mode_select_low;
    logic                        clock_polarity_bit;
    logic                        clock_phase_bit;
    logic                        data_order_bit;
    logic                        transmitter_enable;
    logic                        receiver_enable;
    logic [`USM_DIV_WIDTH-1:0]   baud_divisor;
  } usm_config_type;

endpackage : usm_pkg

// ---- verilog/usm_fifo.sv ----
/*
  Holds a parameterised synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and an asynchronous active-high reset.
*/
module usm_fifo
  import usm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `USM_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  // Flush
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } usm_fifo_state_type;

  usm_fifo_state_type state;
  usm_fifo_state_type next_state;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  assign in_ready  = (state.count != (AW+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data  = mem[state.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_state = state;
    if (flush) begin
      next_state = '0;
    end else begin
      if (push) begin
        next_state.wr_ptr = (state.wr_ptr == AW'(DEPTH-1)) ? '0 : state.wr_ptr + 1'b1;
      end
      if (pop) begin
        next_state.rd_ptr = (state.rd_ptr == AW'(DEPTH-1)) ? '0 : state.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        next_state.count = state.count + 1'b1;
      end else if (pop && !push) begin
        next_state.count = state.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (push && !flush) begin
      mem[state.wr_ptr] <= in_data;
    end
  end
endmodule : usm_fifo

// ---- verilog/usm_baud.sv ----
/*
  Holds the baud generator: a tick every divisor+1 system clocks, giving half-bit steps.
  Assumes a single clock; restart loads the divisor at once.
*/
module usm_baud
  import usm_pkg::*;
#(
  parameter int DIV_WIDTH = `USM_DIV_WIDTH
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // Control
  input  wire logic                 run,
  input  wire logic [DIV_WIDTH-1:0] divisor,
  // Tick
  output logic                      tick
);
  typedef struct packed {
    logic [DIV_WIDTH-1:0] count;
  } usm_baud_state_type;

  usm_baud_state_type state;
  usm_baud_state_type next_state;

  assign tick = run && (state.count == '0);

  always_comb begin
    next_state = state;
    if (!run || state.count == '0) begin
      next_state.count = divisor;
    end else begin
      next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule : usm_baud

// ---- verification/usm_master_sva.sv ----
/*
  Concurrent checks on the ports of the master SPI block.
  Assumes binding to usm_master and a single clock domain.
*/
module usm_master_sva
  import usm_pkg::*;
#(
  parameter int DIV_WIDTH = `USM_DIV_WIDTH
) (
  // Clock and reset
  input wire logic                 CLOCK,
  input wire logic                 SYS_RST,
  // Configuration
  input wire logic                 MODE_SELECT_HIGH,
  input wire logic                 MODE_SELECT_LOW,
  input wire logic                 CLOCK_POLARITY_BIT,
  input wire logic                 TRANSMITTER_ENABLE,
  input wire logic                 SERIAL_CLOCK_PIN_DIRECTION,
  input wire logic [DIV_WIDTH-9:0] BAUD_DIVISOR_HIGH,
  input wire logic                 BAUD_DIVISOR_HIGH_WRITE,
  input wire logic [7:0]           BAUD_DIVISOR_LOW,
  input wire logic                 BAUD_DIVISOR_LOW_WRITE,
  // Status
  input wire logic                 TRANSMIT_COMPLETE_FLAG,
  input wire logic                 DATA_REGISTER_EMPTY_FLAG,
  input wire logic                 FRAME_ERROR_FLAG,
  input wire logic                 DATA_OVERRUN_FLAG,
  input wire logic                 PARITY_ERROR_FLAG,
  input wire logic [DIV_WIDTH-1:0] BAUD_DIVISOR,
  // Serial pins
  input wire logic                 SERIAL_CLOCK_PIN,
  input wire logic                 SERIAL_CLOCK_PIN_OE_N,
  input wire logic                 SERIAL_DATA_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ****************************************
  // Clock half-period counter
  // ****************************************
  logic [15:0] gap;
  logic        prev_sck;
  logic        seen;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gap <= 16'h0000;
      prev_sck <= 1'b0;
      seen <= 1'b0;
    end else begin
      gap <= (SERIAL_CLOCK_PIN != prev_sck) ? 16'h0000 : gap + 16'(gap != 16'hFFFF);
      prev_sck <= SERIAL_CLOCK_PIN;
      seen <= seen | (SERIAL_CLOCK_PIN != prev_sck);
    end
  end
  sequence dir_out_held;
    SERIAL_CLOCK_PIN_DIRECTION [*2];
  endsequence
  sequence dir_in_held;
    !SERIAL_CLOCK_PIN_DIRECTION [*2];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  err_flags_zero_a: assert property (!FRAME_ERROR_FLAG && !DATA_OVERRUN_FLAG && !PARITY_ERROR_FLAG)
    else $error("error flag set");
  idle_data_high_a: assert property ($rose(TRANSMIT_COMPLETE_FLAG) |->
    SERIAL_CLOCK_PIN == CLOCK_POLARITY_BIT ##1 SERIAL_DATA_OUT) else $error("line not idle at completion");
  clk_half_period_a: assert property ((SERIAL_CLOCK_PIN != prev_sck) && seen &&
    prev_sck != CLOCK_POLARITY_BIT |-> gap == 16'(BAUD_DIVISOR)) else $error("clock half period wrong");
  clk_dir_out_a: assert property (dir_out_held |-> !SERIAL_CLOCK_PIN_OE_N)
    else $error("clock pin not driven");
  clk_dir_in_a: assert property (dir_in_held |-> SERIAL_CLOCK_PIN_OE_N)
    else $error("clock pin driven as input");
  div_low_write_a: assert property (BAUD_DIVISOR_LOW_WRITE |=> BAUD_DIVISOR[7:0] == $past(BAUD_DIVISOR_LOW))
    else $error("divisor low not stored");
  div_high_write_a: assert property (BAUD_DIVISOR_HIGH_WRITE |=>
    BAUD_DIVISOR[DIV_WIDTH-1:8] == $past(BAUD_DIVISOR_HIGH)) else $error("divisor high not stored");
  off_clock_quiet_a: assert property (!(TRANSMITTER_ENABLE && MODE_SELECT_HIGH && MODE_SELECT_LOW) &&
    SERIAL_CLOCK_PIN == CLOCK_POLARITY_BIT |=> $stable(SERIAL_CLOCK_PIN)) else $error("clock moved while off");
  pair_done_a: assert property (!DATA_REGISTER_EMPTY_FLAG |=> !$rose(TRANSMIT_COMPLETE_FLAG))
    else $error("completion with byte queued");
endmodule // usm_master_sva

// ---- verification/usm_spi_slave.sv ----
/*
  Behavioural external SPI slave: samples and drives by polarity, phase and bit order.
  Assumes clean clock edges from the master and the bench reset.
*/
module usm_spi_slave (
  // Control
  input  wire logic       rst,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       msb_first,
  input  wire logic [7:0] reply,
  // Serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Received
  output logic      [7:0] got,
  output int              n_got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shin;
  logic [7:0] tx;
  logic [2:0] bi;
  logic [2:0] ob;
  logic       act;
  int         ns;
  assign tx = reply + n_got[7:0];
  assign ob = msb_first ? 3'h7 - bi : bi;
  // Released line shows inverted data in phase-one modes
  assign miso = (cpha && !act) ? ~tx[ob] : tx[ob];
  always @(posedge rst) begin
    ns = 0;
    bi = 3'h0;
    act = 1'b0;
    n_got = 0;
    got = 8'h00;
  end
  always @(sck) begin
    if (!rst) begin
      if (((sck != cpol) ^ cpha) && (act || !cpha)) begin
        shin[msb_first ? 7 - ns : ns] = mosi;
        ns++;
        if (ns == 8) begin
          got = shin;
          ns = 0;
          act = 1'b0;
          n_got++;
        end
      end else begin
        bi = 3'(ns);
        act = 1'b1;
      end
    end
  end
endmodule // usm_spi_slave

// ---- verification/tb_usm_master.sv ----
/*
  Self-checking bench of the master SPI block with a behavioural slave.
  Assumes the design package and include path are compiled first.
*/
module tb_usm_master;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK, SYS_RST, MODE_SELECT_HIGH, MODE_SELECT_LOW, CLOCK_POLARITY_BIT, CLOCK_PHASE_BIT;
  logic DATA_ORDER_BIT, TRANSMITTER_ENABLE, RECEIVER_ENABLE, SERIAL_CLOCK_PIN_DIRECTION;
  logic [3:0]  BAUD_DIVISOR_HIGH;
  logic [7:0]  BAUD_DIVISOR_LOW, DATA_WRITE, DATA_READ, reply, got;
  logic [11:0] BAUD_DIVISOR;
  logic BAUD_DIVISOR_HIGH_WRITE, BAUD_DIVISOR_LOW_WRITE, DATA_WRITE_STROBE, DATA_READ_STROBE;
  logic TRANSMIT_COMPLETE_CLEAR, RECEIVE_COMPLETE_FLAG, TRANSMIT_COMPLETE_FLAG, DATA_REGISTER_EMPTY_FLAG;
  logic FRAME_ERROR_FLAG, DATA_OVERRUN_FLAG, PARITY_ERROR_FLAG;
  logic SERIAL_CLOCK_PIN, SERIAL_CLOCK_PIN_OE_N, SERIAL_DATA_OUT, SERIAL_DATA_IN;
  int   num_errors, n_checks, n_got;
  usm_master u_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .MODE_SELECT_HIGH(MODE_SELECT_HIGH),
    .MODE_SELECT_LOW(MODE_SELECT_LOW), .CLOCK_POLARITY_BIT(CLOCK_POLARITY_BIT), .CLOCK_PHASE_BIT(CLOCK_PHASE_BIT),
    .DATA_ORDER_BIT(DATA_ORDER_BIT), .TRANSMITTER_ENABLE(TRANSMITTER_ENABLE), .RECEIVER_ENABLE(RECEIVER_ENABLE),
    .SERIAL_CLOCK_PIN_DIRECTION(SERIAL_CLOCK_PIN_DIRECTION), .BAUD_DIVISOR_HIGH(BAUD_DIVISOR_HIGH),
    .BAUD_DIVISOR_HIGH_WRITE(BAUD_DIVISOR_HIGH_WRITE), .BAUD_DIVISOR_LOW(BAUD_DIVISOR_LOW),
    .BAUD_DIVISOR_LOW_WRITE(BAUD_DIVISOR_LOW_WRITE), .DATA_WRITE(DATA_WRITE), .DATA_WRITE_STROBE(DATA_WRITE_STROBE),
    .DATA_READ_STROBE(DATA_READ_STROBE), .TRANSMIT_COMPLETE_CLEAR(TRANSMIT_COMPLETE_CLEAR), .DATA_READ(DATA_READ),
    .RECEIVE_COMPLETE_FLAG(RECEIVE_COMPLETE_FLAG), .TRANSMIT_COMPLETE_FLAG(TRANSMIT_COMPLETE_FLAG),
    .DATA_REGISTER_EMPTY_FLAG(DATA_REGISTER_EMPTY_FLAG), .FRAME_ERROR_FLAG(FRAME_ERROR_FLAG),
    .DATA_OVERRUN_FLAG(DATA_OVERRUN_FLAG), .PARITY_ERROR_FLAG(PARITY_ERROR_FLAG), .BAUD_DIVISOR(BAUD_DIVISOR),
    .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_CLOCK_PIN_OE_N(SERIAL_CLOCK_PIN_OE_N),
    .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_IN(SERIAL_DATA_IN));
  usm_spi_slave u_slave (.rst(SYS_RST), .cpol(CLOCK_POLARITY_BIT), .cpha(CLOCK_PHASE_BIT),
    .msb_first(DATA_ORDER_BIT), .reply(reply), .sck(SERIAL_CLOCK_PIN), .mosi(SERIAL_DATA_OUT),
    .miso(SERIAL_DATA_IN), .got(got), .n_got(n_got));
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic tick(int n = 1);
    repeat (n) @(posedge CLOCK);
    #10;
  endtask
  task automatic chk(string name, logic [11:0] exp, logic [11:0] seen);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_flag(int which);
    int k;
    k = 0;
    while (k < 3000 && ((which == 0) ? DATA_REGISTER_EMPTY_FLAG : (which == 1) ? TRANSMIT_COMPLETE_FLAG :
           (which == 2) ? RECEIVE_COMPLETE_FLAG : (n_got == which)) !== 1'b1) begin
      tick();
      k++;
    end
    chk("wait done", 12'h001, 12'(k < 3000));
  endtask
  task automatic wdiv(logic [11:0] d);
    BAUD_DIVISOR_HIGH = d[11:8];
    BAUD_DIVISOR_LOW = d[7:0];
    BAUD_DIVISOR_HIGH_WRITE = 1'b1;
    BAUD_DIVISOR_LOW_WRITE = 1'b1;
    tick();
    BAUD_DIVISOR_HIGH_WRITE = 1'b0;
    BAUD_DIVISOR_LOW_WRITE = 1'b0;
    tick();
    chk("divisor", d, BAUD_DIVISOR);
  endtask
  task automatic send(logic [7:0] b);
    wait_flag(0);
    TRANSMIT_COMPLETE_CLEAR = 1'b1;
    tick();
    TRANSMIT_COMPLETE_CLEAR = 1'b0;
    DATA_WRITE = b;
    DATA_WRITE_STROBE = 1'b1;
    tick();
    DATA_WRITE_STROBE = 1'b0;
  endtask
  task automatic rd(logic [7:0] exp);
    wait_flag(2);
    chk("read data", 12'(exp), 12'(DATA_READ));
    DATA_READ_STROBE = 1'b1;
    tick();
    DATA_READ_STROBE = 1'b0;
    tick();
  endtask
  task automatic start(logic [2:0] m, logic [11:0] d);
    SYS_RST = 1'b1;
    {CLOCK_POLARITY_BIT, CLOCK_PHASE_BIT, DATA_ORDER_BIT} = m;
    TRANSMITTER_ENABLE = 1'b0;
    RECEIVER_ENABLE = 1'b0;
    SERIAL_CLOCK_PIN_DIRECTION = 1'b0;
    tick(10);
    SYS_RST = 1'b0;
    tick(2);
    chk("divisor at reset", 12'h000, BAUD_DIVISOR);
    chk("idle flags", 12'h005, {9'h000, DATA_REGISTER_EMPTY_FLAG, TRANSMIT_COMPLETE_FLAG, SERIAL_DATA_OUT});
    SERIAL_CLOCK_PIN_DIRECTION = 1'b1;
    tick();
    TRANSMITTER_ENABLE = 1'b1;
    RECEIVER_ENABLE = 1'b1;
    tick();
    wdiv(d);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {MODE_SELECT_HIGH, MODE_SELECT_LOW, DATA_WRITE, DATA_WRITE_STROBE, DATA_READ_STROBE} = {2'h3, 10'h000};
    {BAUD_DIVISOR_HIGH, BAUD_DIVISOR_LOW, BAUD_DIVISOR_HIGH_WRITE, BAUD_DIVISOR_LOW_WRITE} = 14'h0000;
    TRANSMIT_COMPLETE_CLEAR = 1'b0;
    reply = 8'h3C;
    num_errors = 0;
    n_checks = 0;
    start(3'h0, 12'hFFF);
    for (int m = 0; m < 8; m++) begin
      start(m[2:0], (m == 3) ? 12'h000 : 12'h002);
      send(8'h1D + 8'(m));
      wait_flag(1);
      chk("slave byte", 12'h01D + 12'(m), 12'(got));
      rd(8'h3C);
    end
    send(8'hC3);
    send(8'h5A);
    wait_flag(3);
    wait_flag(1);
    chk("second byte", 12'h05A, 12'(got));
    rd(8'h3D);
    rd(8'h3E);
    for (int k = 0; k < 2; k++) begin
      MODE_SELECT_LOW = 1'(k);
      TRANSMITTER_ENABLE = 1'(1 - k);
      send(8'hFF);
      tick(60);
      chk("frames", 12'h003, 12'(n_got));
    end
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    num_errors++;
    end_of_test();
  end
endmodule // tb_usm_master
bind usm_master usm_master_sva #(.DIV_WIDTH(DIV_WIDTH)) u_sva (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .MODE_SELECT_HIGH(MODE_SELECT_HIGH), .MODE_SELECT_LOW(MODE_SELECT_LOW), .CLOCK_POLARITY_BIT(CLOCK_POLARITY_BIT),
  .TRANSMITTER_ENABLE(TRANSMITTER_ENABLE), .SERIAL_CLOCK_PIN_DIRECTION(SERIAL_CLOCK_PIN_DIRECTION),
  .BAUD_DIVISOR_HIGH(BAUD_DIVISOR_HIGH), .BAUD_DIVISOR_HIGH_WRITE(BAUD_DIVISOR_HIGH_WRITE),
  .BAUD_DIVISOR_LOW(BAUD_DIVISOR_LOW), .BAUD_DIVISOR_LOW_WRITE(BAUD_DIVISOR_LOW_WRITE),
  .TRANSMIT_COMPLETE_FLAG(TRANSMIT_COMPLETE_FLAG), .DATA_REGISTER_EMPTY_FLAG(DATA_REGISTER_EMPTY_FLAG),
  .FRAME_ERROR_FLAG(FRAME_ERROR_FLAG), .DATA_OVERRUN_FLAG(DATA_OVERRUN_FLAG), .PARITY_ERROR_FLAG(PARITY_ERROR_FLAG),
  .BAUD_DIVISOR(BAUD_DIVISOR), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_CLOCK_PIN_OE_N(SERIAL_CLOCK_PIN_OE_N),
  .SERIAL_DATA_OUT(SERIAL_DATA_OUT));
